// *** bench/cable_device_model.sv ***
/*
 Cable device at the connector: echoes whatever the block transmits onto
 the paired receive line. Assumes released lines float with no pull.
*/
`timescale 1ns/1ps
module cable_device_model
  import port_route_pkg::*;
(
  input  wire logic     core_clk,
  input  wire pin_out_s top_dplus_pin,
  input  wire pin_out_s bottom_dplus_pin,
  input  wire pin_out_s sideband_pin_a,
  input  wire pin_out_s sideband_pin_b,
  output logic          top_dminus_pin,
  output logic          bottom_dminus_pin,
  output logic          sideband_pin_a_i,
  output logic          sideband_pin_b_i
);
  logic churn_q = 1'b0;

  // Floating lines change every cycle so a stale level never looks valid
  always_ff @(posedge core_clk) begin
    churn_q <= !churn_q;
  end

  assign top_dminus_pin    = top_dplus_pin.oe_n ? churn_q : top_dplus_pin.o;
  assign bottom_dminus_pin = bottom_dplus_pin.oe_n ? churn_q : bottom_dplus_pin.o;
  assign sideband_pin_a_i  = !sideband_pin_a.oe_n ? sideband_pin_a.o : (!sideband_pin_b.oe_n ? sideband_pin_b.o : churn_q);
  assign sideband_pin_b_i  = !sideband_pin_b.oe_n ? sideband_pin_b.o : (!sideband_pin_a.oe_n ? sideband_pin_a.o : churn_q);
endmodule : cable_device_model

// *** bench/port_data_mux_routing_properties.sv ***
/*
 Concurrent checks on the ports of the routing block: register readback,
 orientation swap, fixed path sets, pin release and reset bypass.
 Assumes the single core clock and the synchronous active-high reset.
*/
`timescale 1ns/1ps
module port_route_checker
  import port_route_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         reset,
  input wire logic [7:0]   reg_addr,
  input wire logic [31:0]  reg_wdata,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic [31:0]  reg_rdata,
  input wire logic [5:0]   xbar_pin_i,
  input wire logic [5:0]   xbar_pin_o,
  input wire logic [5:0]   xbar_pin_oe_n,
  input wire pin_out_s     top_dplus_pin,
  input wire pin_out_s     bottom_dplus_pin,
  input wire pin_out_s     sideband_pin_a,
  input wire pin_out_s     sideband_pin_b,
  input wire switch_ctrl_s mux_switches,
  input wire logic         sideband_swap,
  input wire logic         lsx_analog_pass
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence sel_write;
    reg_wr && reg_addr == OFF_PORT_SEL;
  endsequence
  sequence sel_read;
    reg_rd && reg_addr == OFF_PORT_SEL;
  endsequence
  sequence ctrl_write;
    reg_wr && reg_addr == OFF_ROUTE_CTRL;
  endsequence

  sel_readback_a: assert property (
    sel_write ##1 sel_read |=> reg_rdata == {20'h0, $past(reg_wdata[11:0], 2)})
    else $error("port select readback wrong");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  orient_swap_a: assert property (
    ctrl_write |-> ##2 sideband_swap == $past(reg_wdata[CTRL_FLIP_BIT], 2))
    else $error("orientation not applied two cycles after write");
  pair_fixed_a: assert property (
    $onehot0(mux_switches.top) && $onehot0(mux_switches.bottom) && !mux_switches.top[0] && !mux_switches.bottom[0]
    && !mux_switches.top[SRC_LSX] && !mux_switches.bottom[SRC_LSX])
    else $error("pair closure outside fixed set");
  sideband_fixed_a: assert property (
    $onehot0(mux_switches.sideband) && mux_switches.sideband[2:0] == 3'h0)
    else $error("sideband closure outside fixed set");
  sideband_orient_a: assert property (
    !sideband_pin_a.oe_n || !sideband_pin_b.oe_n
    |-> sideband_pin_a.oe_n == sideband_swap && sideband_pin_b.oe_n == !sideband_swap)
    else $error("sideband transmit pin against orientation");
  top_release_a: assert property (
    !top_dplus_pin.oe_n |-> mux_switches.top[SRC_LANE])
    else $error("top pin driven without lane path");
  bottom_release_a: assert property (
    !bottom_dplus_pin.oe_n |-> mux_switches.bottom[SRC_LANE])
    else $error("bottom pin driven without lane path");
  analog_pass_a: assert property (
    lsx_analog_pass |-> mux_switches.sideband[SRC_LSX] && sideband_pin_a.oe_n && sideband_pin_b.oe_n)
    else $error("analog pass with digital drive");
  // Reset itself is the cause here, so these two are never disabled
  reset_hold_a: assert property (disable iff (1'b0)
    reset |=> xbar_pin_oe_n == XPIN_OE_N_RST && mux_switches == 27'h0 && top_dplus_pin.oe_n)
    else $error("outputs not at reset state");
  reset_bypass_a: assert property (disable iff (1'b0)
    (reset && $stable(xbar_pin_i[0]))[*6] |-> xbar_pin_o[1] == xbar_pin_i[0])
    else $error("serial bypass not passing during reset");
endmodule : port_route_checker

bind port_data_mux_routing port_route_checker i_port_route_checker (
  .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xbar_pin_i(xbar_pin_i), .xbar_pin_o(xbar_pin_o),
  .xbar_pin_oe_n(xbar_pin_oe_n), .top_dplus_pin(top_dplus_pin), .bottom_dplus_pin(bottom_dplus_pin),
  .sideband_pin_a(sideband_pin_a), .sideband_pin_b(sideband_pin_b), .mux_switches(mux_switches),
  .sideband_swap(sideband_swap), .lsx_analog_pass(lsx_analog_pass));

// *** bench/port_data_mux_routing_tb.sv ***
/*
 Self-checking bench for the routing block: table of path selections, then
 crossbar loopback through the cable model, release, tri-state and reset.
 Assumes the cable model echoes transmit lines onto receive lines.
*/
`timescale 1ns/1ps
module port_data_mux_routing_tb
  import port_route_pkg::*;
;
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [11:0] sel;
    logic [26:0] sw;
    logic        swap;
    logic        analog;
  } row_s;
  localparam row_s ROWS [7] = '{
    '{4'h0, 12'h321, 27'h0200802, 1'b0, 1'b0}, '{4'h1, 12'h321, 27'h0200404, 1'b1, 1'b0},
    '{4'h0, 12'h154, 27'h0004010, 1'b0, 1'b0}, '{4'h0, 12'h876, 27'h4010040, 1'b0, 1'b0},
    '{4'h2, 12'h888, 27'h4000000, 1'b0, 1'b1}, '{4'h0, 12'h629, 27'h1000800, 1'b0, 1'b0},
    '{4'h1, 12'h2F7, 27'h0010000, 1'b1, 1'b0}};
  localparam logic [39:0] RST_TAB [7] = '{{8'h00, 32'h0}, {8'h04, 32'h0}, {8'h08, 32'h02},
    {8'h0C, 32'hFFFF3F}, {8'h10, 32'hFFF}, {8'h18, 32'h0}, {8'h1C, 32'h0}};

  logic         core_clk;
  logic         reset;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [31:0]  reg_rdata;
  logic [5:0]   xbar_pin_i;
  logic [5:0]   xbar_pin_o;
  logic [5:0]   xbar_pin_oe_n;
  pin_out_s     top_dplus_pin;
  pin_out_s     bottom_dplus_pin;
  pin_out_s     sideband_pin_a;
  pin_out_s     sideband_pin_b;
  logic         top_dminus_pin;
  logic         bottom_dminus_pin;
  logic         sideband_pin_a_i;
  logic         sideband_pin_b_i;
  switch_ctrl_s mux_switches;
  logic         sideband_swap;
  logic         lsx_analog_pass;
  logic [31:0]  rd_data;
  int           miscompares = 0;
  int           n_compared = 0;

  port_data_mux_routing i_port_data_mux_routing (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xbar_pin_i(xbar_pin_i), .xbar_pin_o(xbar_pin_o),
    .xbar_pin_oe_n(xbar_pin_oe_n), .top_dplus_pin(top_dplus_pin), .top_dminus_pin(top_dminus_pin),
    .bottom_dplus_pin(bottom_dplus_pin), .bottom_dminus_pin(bottom_dminus_pin),
    .sideband_pin_a_i(sideband_pin_a_i), .sideband_pin_b_i(sideband_pin_b_i), .sideband_pin_a(sideband_pin_a),
    .sideband_pin_b(sideband_pin_b), .mux_switches(mux_switches), .sideband_swap(sideband_swap),
    .lsx_analog_pass(lsx_analog_pass));

  cable_device_model i_cable_device_model (
    .core_clk(core_clk), .top_dplus_pin(top_dplus_pin), .bottom_dplus_pin(bottom_dplus_pin),
    .sideband_pin_a(sideband_pin_a), .sideband_pin_b(sideband_pin_b), .top_dminus_pin(top_dminus_pin),
    .bottom_dminus_pin(bottom_dminus_pin), .sideband_pin_a_i(sideband_pin_a_i), .sideband_pin_b_i(sideband_pin_b_i));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = !core_clk;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    // Off the edge, so a back-to-back strobe is a fresh assignment
    #1;
  endtask : reg_write

  // Data stands only in the cycle after the strobe, so sample it there
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  initial begin
    #(2000 * 100);
    miscompares++;
    finish_test();
  end

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    xbar_pin_i = 6'h00;
    repeat (1) @(posedge core_clk);
    xbar_pin_i <= 6'h01;
    step(6);
    check("bypass in reset", 32'h1, xbar_pin_o[1]);
    check("crossbar enables in reset", 32'h3D, xbar_pin_oe_n);
    reset <= 1'b0;
    xbar_pin_i <= 6'h00;
    step(8);
    check("bypass after reset", 32'h0, xbar_pin_o[1]);
    foreach (ROWS[i]) begin
      reg_write(OFF_ROUTE_CTRL, {28'h0, ROWS[i].ctrl});
      reg_write(OFF_PORT_SEL, {20'h0, ROWS[i].sel});
      reg_read(OFF_PORT_SEL, rd_data);
      check("port select readback", {20'h0, ROWS[i].sel}, rd_data);
      step(3);
      check("switch closures", {5'h0, ROWS[i].sw}, mux_switches);
      check("sideband swap", ROWS[i].swap, sideband_swap);
      check("analog pass", ROWS[i].analog, lsx_analog_pass);
      reg_read(OFF_SW_STATUS, rd_data);
      check("switch status", {5'h0, ROWS[i].sw}, rd_data);
    end
    reg_write(OFF_LANE_SRC, 32'h333);
    reg_write(OFF_PIN_SRC, 32'hF3FF0F);
    reg_write(OFF_PIN_DIR, 32'h12);
    reg_write(OFF_ROUTE_CTRL, 32'h0);
    reg_write(OFF_PORT_SEL, 32'h707);
    for (int v = 1; v >= 0; v--) begin
      xbar_pin_i <= {5'h00, v[0]};
      step(14);
      check("top transmit", v, top_dplus_pin.o);
      check("general pin copy", v, xbar_pin_o[4]);
      check("lane 0 echo", v, xbar_pin_o[1]);
      check("sideband transmit", v, sideband_pin_a.o);
      check("crossbar enables", 32'h2D, xbar_pin_oe_n);
      check("upright drives", 32'h5, {top_dplus_pin.oe_n, bottom_dplus_pin.oe_n, sideband_pin_a.oe_n, sideband_pin_b.oe_n});
    end
    reg_write(OFF_ROUTE_CTRL, 32'h1);
    step(4);
    check("flipped drives", 32'hA, {top_dplus_pin.oe_n, bottom_dplus_pin.oe_n, sideband_pin_a.oe_n, sideband_pin_b.oe_n});
    check("flip swap", 32'h1, sideband_swap);
    reg_write(OFF_ROUTE_CTRL, 32'h4);
    step(3);
    check("serial released", 32'h2F, xbar_pin_oe_n);
    reg_write(OFF_PORT_SEL, 32'h807);
    reg_write(OFF_ROUTE_CTRL, 32'h0);
    step(3);
    check("serial pair enables", 32'h29, xbar_pin_oe_n);
    check("serial pair drives", 32'h1, {sideband_pin_a.oe_n, sideband_pin_b.oe_n});
    reg_write(OFF_ROUTE_CTRL, 32'h8);
    step(3);
    check("serial pair released", 32'h2D, xbar_pin_oe_n);
    check("serial sideband released", 32'h3, {sideband_pin_a.oe_n, sideband_pin_b.oe_n});
    reset <= 1'b1;
    step(4);
    reset <= 1'b0;
    step(1);
    // Unmapped write must leave no trace on the readback
    reg_write(8'h1C, 32'hFFFFFFFF);
    foreach (RST_TAB[i]) begin
      reg_read(RST_TAB[i][39:32], rd_data);
      check("register reset value", RST_TAB[i][31:0], rd_data);
    end
    finish_test();
  end
endmodule : port_data_mux_routing_tb

// *** rtl/pin_sync.sv ***
/*
 Three-stage input synchroniser for one asynchronous pin.
 Assumes the pin is driven to a valid level; stages carry no reset so a
 pass-through fed by them keeps running while reset is held.
*/
`timescale 1ns/1ps
module pin_sync (
  input  wire logic core_clk,
  input  wire logic raw,
  output logic      clean
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;

  always_ff @(posedge core_clk) begin
    stage1_q <= raw;
    stage2_q <= stage1_q;
    stage3_q <= stage2_q;
  end

  // Only accept a level once the last two stages agree
  always_ff @(posedge core_clk) begin
    if (stage2_q == stage3_q) begin
      clean <= stage3_q;
    end
  end

endmodule : pin_sync

// *** rtl/port_data_mux_routing.sv ***
/*
 Routing control for the connector-side data multiplexer: pair and sideband
 path selection with orientation swap, and the digital serial crossbar.
 Assumes a single 10 MHz core clock, a synchronous active-high reset and a
 plain register port with read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
// Function
// - Each multiplexer output is chosen from the cable orientation and the selected interface kind.
// - The top and bottom D+/D- pairs are exchanged when the cable is reversed.
// - Pair paths are a fixed set and a positive line only reaches D+, a negative line only D-.
// - The sideband crossbar swaps the two sideband pins as a pair when the plug is flipped.
// - Nominal sideband mapping puts clock and positive lines on pin A, data and negative on pin B, upright only.
// - Lane 0 serves the top pair, lane 1 the bottom pair, lane 2 the sideband pins with transmit on A upright, on B flipped.
// - Both serial paths and both general pins go through the crossbar and may feed any lane.
// - Each crossbar pin is set individually as crossbar input or output.
// - Every crossbar link and every path selection can be changed by firmware at run time.
// - After power-up the system serial output carries a buffered copy of the system serial input.
// - That pass-through stays active while reset is held.
// - Both serial paths are buffered and each has a tri-state release.
// - The port serial pair can act as a plain analog pass switch instead of a buffered path.
// - Core-side signals are sampled and driven by the core clock, which bounds their data rate.
// - High-speed pairs are not routed; only D+/D- pairs and sideband pins pass through.
module port_data_mux_routing
  import port_route_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  input  wire logic [5:0]   xbar_pin_i,
  output logic      [5:0]   xbar_pin_o,
  output logic      [5:0]   xbar_pin_oe_n,
  output pin_out_s          top_dplus_pin,
  input  wire logic         top_dminus_pin,
  output pin_out_s          bottom_dplus_pin,
  input  wire logic         bottom_dminus_pin,
  input  wire logic         sideband_pin_a_i,
  input  wire logic         sideband_pin_b_i,
  output pin_out_s          sideband_pin_a,
  output pin_out_s          sideband_pin_b,
  output switch_ctrl_s      mux_switches,
  output logic              sideband_swap,
  output logic              lsx_analog_pass
);

  logic [CTRL_W-1:0]          ctrl_q;
  logic [SEL_W-1:0]           port_sel_q;
  logic [XPIN_N-1:0]          pin_dir_q;
  logic [XPIN_N*CODE_W-1:0]   pin_src_q;
  logic [LANE_N*CODE_W-1:0]   lane_src_q;
  logic [SYNC_N-1:0]          sync_raw;
  logic [SYNC_N-1:0]          clean;
  logic [LANE_N-1:0]          lane_rx;
  logic [LANE_N-1:0]          lane_tx_q;
  logic [LANE_N-1:0]          lane_tx_d;
  logic [LANE_N-1:0]          lane_ok;
  logic [XPIN_N-1:0]          xpin_o_d;
  logic [XPIN_N-1:0]          xpin_en_d;
  logic                       flip;
  logic                       analog;
  logic                       lsx_digital;
  logic                       sb_tx;
  logic                       sb_drive;
  pair_src_e                  top_src;
  pair_src_e                  bottom_src;
  pair_src_e                  sb_src;
  switch_ctrl_s               switches_d;

  // Crossbar source pick: lanes first, then pins; anything else is idle low
  function automatic logic xsrc_bit(input logic [3:0] code, input logic [LANE_N-1:0] rx,
                                    input logic [XPIN_N-1:0] pins);
    logic [3:0] idx;
    idx = code - XSRC_PIN_BASE;
    if (code < XSRC_PIN_BASE) begin
      xsrc_bit = rx[code[1:0]];
    end else if (code < XSRC_LIMIT) begin
      xsrc_bit = pins[idx[2:0]];
    end else begin
      xsrc_bit = 1'b0;
    end
  endfunction : xsrc_bit

  function automatic logic xsrc_ok(input logic [3:0] code);
    xsrc_ok = (code < XSRC_LIMIT);
  endfunction : xsrc_ok

  // D+/D- pairs only take pair sources, never the sideband serial pair
  function automatic pair_src_e legal_pair(input logic [3:0] code);
    if (code == SRC_LSX || code >= 4'(SRC_N)) begin
      legal_pair = SRC_OFF;
    end else begin
      legal_pair = pair_src_e'(code);
    end
  endfunction : legal_pair

  // Sideband carries no root port or endpoint pair
  function automatic pair_src_e legal_sideband(input logic [3:0] code);
    if (code == SRC_ROOT || code == SRC_ENDPOINT || code >= 4'(SRC_N)) begin
      legal_sideband = SRC_OFF;
    end else begin
      legal_sideband = pair_src_e'(code);
    end
  endfunction : legal_sideband

  // One closed switch per output group, off means all open
  function automatic logic [8:0] closure(input pair_src_e src);
    logic [8:0] one;
    one = 9'h001 << src;
    closure = one & 9'h1FE;
  endfunction : closure

  // Every pin the core touches is resampled on core_clk
  assign sync_raw = {sideband_pin_b_i, sideband_pin_a_i, bottom_dminus_pin, top_dminus_pin, xbar_pin_i};

  genvar g;
  generate
    for (g = 0; g < SYNC_N; g = g + 1) begin : g_sync
      pin_sync u_sync (
        .core_clk (core_clk),
        .raw      (sync_raw[g]),
        .clean    (clean[g])
      );
    end
  endgenerate

  // Firmware writes take effect on the next cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q     <= CTRL_RST;
      port_sel_q <= SEL_RST;
      pin_dir_q  <= PIN_DIR_RST;
      pin_src_q  <= PIN_SRC_RST;
      lane_src_q <= LANE_SRC_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_ROUTE_CTRL: ctrl_q     <= reg_wdata[CTRL_W-1:0];
        OFF_PORT_SEL:   port_sel_q <= reg_wdata[SEL_W-1:0];
        OFF_PIN_DIR:    pin_dir_q  <= reg_wdata[XPIN_N-1:0];
        OFF_PIN_SRC:    pin_src_q  <= reg_wdata[XPIN_N*CODE_W-1:0];
        OFF_LANE_SRC:   lane_src_q <= reg_wdata[LANE_N*CODE_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // One orientation bit feeds both swaps
  assign flip   = ctrl_q[CTRL_FLIP_BIT];
  assign analog = ctrl_q[CTRL_ANALOG_BIT];

  // Path choice from orientation plus interface kind
  always_comb begin
    // Primary pair lands on top upright, on bottom when reversed
    if (flip) begin
      top_src    = legal_pair(port_sel_q[SEL_SECONDARY_LSB +: 4]);
      bottom_src = legal_pair(port_sel_q[SEL_PRIMARY_LSB +: 4]);
    end else begin
      top_src    = legal_pair(port_sel_q[SEL_PRIMARY_LSB +: 4]);
      bottom_src = legal_pair(port_sel_q[SEL_SECONDARY_LSB +: 4]);
    end
    sb_src = legal_sideband(port_sel_q[SEL_SIDEBAND_LSB +: 4]);
  end

  // Analog pass leaves the serial pair to the switch, digital buffers off
  assign lsx_digital = (sb_src == SRC_LSX) && !analog;

  // Lane receive taps are fixed to their own port group
  always_comb begin
    lane_rx[0] = clean[SYNC_TOP_DM];
    lane_rx[1] = clean[SYNC_BOT_DM];
    // Receive moves to pin A when flipped
    lane_rx[2] = flip ? clean[SYNC_SB_A] : clean[SYNC_SB_B];
  end

  // Any pin may drive any lane
  generate
    for (g = 0; g < LANE_N; g = g + 1) begin : g_lane
      assign lane_tx_d[g] = xsrc_bit(lane_src_q[g*CODE_W +: CODE_W], lane_rx, clean[XPIN_N-1:0]);
      assign lane_ok[g]   = xsrc_ok(lane_src_q[g*CODE_W +: CODE_W]);
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < XPIN_N; i++) begin
      xpin_o_d[i]  = xsrc_bit(pin_src_q[i*CODE_W +: CODE_W], lane_rx, clean[XPIN_N-1:0]);
      xpin_en_d[i] = pin_dir_q[i] && xsrc_ok(pin_src_q[i*CODE_W +: CODE_W]);
    end
    // The sideband serial route owns its two pins, so it overrides the crossbar
    if (sb_src == SRC_LSX) begin
      xpin_o_d[XPIN_P2R]  = lane_rx[2];
      xpin_en_d[XPIN_P2R] = lsx_digital;
      xpin_o_d[XPIN_R2P]  = 1'b0;
      xpin_en_d[XPIN_R2P] = 1'b0;
    end
    if (ctrl_q[CTRL_SYS_HIZ_BIT]) begin
      xpin_en_d[XPIN_SYS_IN]  = 1'b0;
      xpin_en_d[XPIN_SYS_OUT] = 1'b0;
    end
    if (ctrl_q[CTRL_LSX_HIZ_BIT]) begin
      xpin_en_d[XPIN_P2R] = 1'b0;
      xpin_en_d[XPIN_R2P] = 1'b0;
    end
  end

  // Reset values make the system serial output a copy of its input
  always_ff @(posedge core_clk) begin
    if (reset) begin
      xbar_pin_o    <= '0;
      // Bypass keeps running under reset, the syncs are not held
      xbar_pin_o[XPIN_SYS_OUT] <= clean[XPIN_SYS_IN];
      xbar_pin_oe_n <= XPIN_OE_N_RST;
    end else begin
      xbar_pin_o    <= xpin_o_d;
      xbar_pin_oe_n <= ~xpin_en_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lane_tx_q <= '0;
    end else begin
      lane_tx_q <= lane_tx_d;
    end
  end

  // Sideband digital transmit: lane 2 or the buffered serial pair
  always_comb begin
    sb_tx    = 1'b0;
    sb_drive = 1'b0;
    if (sb_src == SRC_LANE) begin
      sb_tx    = lane_tx_q[2];
      sb_drive = lane_ok[2];
    end else if (lsx_digital) begin
      sb_tx    = clean[XPIN_R2P];
      sb_drive = !ctrl_q[CTRL_LSX_HIZ_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      top_dplus_pin    <= '{o: 1'b0, oe_n: 1'b1};
      bottom_dplus_pin <= '{o: 1'b0, oe_n: 1'b1};
      sideband_pin_a   <= '{o: 1'b0, oe_n: 1'b1};
      sideband_pin_b   <= '{o: 1'b0, oe_n: 1'b1};
    end else begin
      // Lane 0 on top D+, lane 1 on bottom D+
      top_dplus_pin.o       <= lane_tx_q[0];
      top_dplus_pin.oe_n    <= !(top_src == SRC_LANE && lane_ok[0]);
      bottom_dplus_pin.o    <= lane_tx_q[1];
      bottom_dplus_pin.oe_n <= !(bottom_src == SRC_LANE && lane_ok[1]);
      // Transmit on A upright, on B flipped
      sideband_pin_a.o      <= sb_tx;
      sideband_pin_a.oe_n   <= !(sb_drive && !flip);
      sideband_pin_b.o      <= sb_tx;
      sideband_pin_b.oe_n   <= !(sb_drive && flip);
    end
  end

  // Only the D+/D- and sideband groups exist; no high-speed closures
  always_comb begin
    switches_d.top      = closure(top_src);
    switches_d.bottom   = closure(bottom_src);
    switches_d.sideband = closure(sb_src);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mux_switches    <= '0;
      sideband_swap   <= 1'b0;
      lsx_analog_pass <= 1'b0;
    end else begin
      mux_switches    <= switches_d;
      // Same bit reaches the sideband crossbar
      sideband_swap   <= flip;
      // Analog pass only when the serial pair is the sideband source
      lsx_analog_pass <= (sb_src == SRC_LSX) && analog;
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_ROUTE_CTRL: reg_rdata <= 32'(ctrl_q);
        OFF_PORT_SEL:   reg_rdata <= 32'(port_sel_q);
        OFF_PIN_DIR:    reg_rdata <= 32'(pin_dir_q);
        OFF_PIN_SRC:    reg_rdata <= 32'(pin_src_q);
        OFF_LANE_SRC:   reg_rdata <= 32'(lane_src_q);
        OFF_PIN_STATUS: reg_rdata <= {12'h000, lane_tx_q, flip, 6'h00, clean};
        OFF_SW_STATUS:  reg_rdata <= 32'(mux_switches);
        default:        reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : port_data_mux_routing

// *** rtl/port_route_pkg.sv ***
/*
 Shared constants and types for the port data multiplexer routing block:
 register offsets, field positions, reset values, source codes and carriers.
 Assumes a 32-bit register port with byte offsets on word boundaries.
*/
package port_route_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_ROUTE_CTRL = 8'h00;
  localparam logic [7:0] OFF_PORT_SEL   = 8'h04;
  localparam logic [7:0] OFF_PIN_DIR    = 8'h08;
  localparam logic [7:0] OFF_PIN_SRC    = 8'h0C;
  localparam logic [7:0] OFF_LANE_SRC   = 8'h10;
  localparam logic [7:0] OFF_PIN_STATUS = 8'h14;
  localparam logic [7:0] OFF_SW_STATUS  = 8'h18;

  // Control register fields
  localparam int CTRL_FLIP_BIT    = 0;
  localparam int CTRL_ANALOG_BIT  = 1;
  localparam int CTRL_SYS_HIZ_BIT = 2;
  localparam int CTRL_LSX_HIZ_BIT = 3;
  localparam int CTRL_W           = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // Port selection fields
  localparam int SEL_PRIMARY_LSB   = 0;
  localparam int SEL_SECONDARY_LSB = 4;
  localparam int SEL_SIDEBAND_LSB  = 8;
  localparam int SEL_W             = 12;
  localparam logic [11:0] SEL_RST  = 12'h000;

  // Crossbar pins
  localparam int XPIN_N       = 6;
  localparam int XPIN_SYS_IN  = 0;
  localparam int XPIN_SYS_OUT = 1;
  localparam int XPIN_P2R     = 2;
  localparam int XPIN_R2P     = 3;
  localparam int XPIN_GPIO1   = 4;
  localparam int XPIN_GPIO2   = 5;
  localparam int LANE_N       = 3;
  localparam int CODE_W       = 4;

  // Crossbar source codes: lanes 0..2, then pins 0..5
  localparam logic [3:0] XSRC_PIN_BASE = 4'h3;
  localparam logic [3:0] XSRC_LIMIT    = 4'h9;
  localparam logic [3:0] XSRC_NONE     = 4'hF;

  // Power-up bypass: system serial in copied to system serial out
  localparam logic [5:0]  PIN_DIR_RST   = 6'h02;
  localparam logic [23:0] PIN_SRC_RST   = 24'hFFFF3F;
  localparam logic [11:0] LANE_SRC_RST  = 12'hFFF;
  localparam logic [5:0]  XPIN_OE_N_RST = 6'h3D;

  // Synchronised input vector layout
  localparam int SYNC_N      = 10;
  localparam int SYNC_TOP_DM = 6;
  localparam int SYNC_BOT_DM = 7;
  localparam int SYNC_SB_A   = 8;
  localparam int SYNC_SB_B   = 9;

  typedef enum logic [3:0] {
    SRC_OFF,
    SRC_ROOT,
    SRC_ENDPOINT,
    SRC_SWD,
    SRC_DEBUG12,
    SRC_DEBUG34,
    SRC_AUX,
    SRC_LANE,
    SRC_LSX
  } pair_src_e;

  localparam int SRC_N = 9;

  typedef struct packed {
    logic o;
    logic oe_n;
  } pin_out_s;

  typedef struct packed {
    logic [8:0] sideband;
    logic [8:0] bottom;
    logic [8:0] top;
  } switch_ctrl_s;

endpackage : port_route_pkg
